// ==== logic/adcc_top.sv ====
// Overview of operation
// - done flag reads 1 after a conversion; high read or control write clears it
// - done flag takes no written value; other control bits read and write
// - converter clock: neither bit half rate, fast full, quarter divides by four
// - power bit turns converter and amplifier on or off, software only
// - top three bits of the low register always read zero
// - select code 0 to 6 picks analog input 0 to 6
// - result high register holds result bits 9 to 2
// - result bits 1 to 0 sit in the low register bits 1 to 0
// - calibrate bit ties amplifier input to 0 V for offset measurement
// - route bit sends input through amplifier when 1, bypass when 0
// - reset clears control/status to zero
// - reset clears low register control bits and result bits to zero
// - powered converter converts selected input continuously, flagging each result
// - changing the input aborts conversion, clears flag, restarts on new input
// - amplifier gives gain of eight, range one eighth of supply
`timescale 1ns/10ps
`include "adcc_defines.svh"
module adcc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output adcc_pkg::adcc_analog_s analog,
    input wire logic comparator_high
);
    typedef enum logic [2:0] {
        SEL_CSR,
        SEL_RESH,
        SEL_RESL,
        SEL_IRQ_STATUS,
        SEL_IRQ_CLEAR,
        SEL_IRQ_ENABLE,
        SEL_NONE
    } adcc_sel_e;

    // address decode shared by the read and write paths
    function automatic adcc_sel_e adcc_decode(input logic [11:0] addr);
        if (addr[1:0] != 2'h0 || addr[11:10] != 2'h0) begin
            adcc_decode = SEL_NONE;
        end else begin
            case (addr[9:2])
                `ADCC_IDX_CSR: adcc_decode = SEL_CSR;
                `ADCC_IDX_RESH: adcc_decode = SEL_RESH;
                `ADCC_IDX_RESL: adcc_decode = SEL_RESL;
                `ADCC_IDX_IRQ_STATUS: adcc_decode = SEL_IRQ_STATUS;
                `ADCC_IDX_IRQ_CLEAR: adcc_decode = SEL_IRQ_CLEAR;
                `ADCC_IDX_IRQ_ENABLE: adcc_decode = SEL_IRQ_ENABLE;
                default: adcc_decode = SEL_NONE;
            endcase
        end
    endfunction : adcc_decode

    // control state
    logic done_flag;
    logic fast;
    logic converter_power_on;
    logic [2:0] input_select;
    logic amp_offset_calibrate;
    logic quarter;
    logic amp_route_select;
    logic [9:0] result;
    logic [`ADCC_IRQ_COUNT-1:0] irq_status;
    logic [`ADCC_IRQ_COUNT-1:0] irq_enable;

    // conversion state
    adcc_pkg::adcc_conv_e conv_state;
    logic [3:0] tick_count;
    logic [3:0] bit_index;
    logic [9:0] trial;
    logic conv_done;
    logic conv_abort;
    logic restart;
    logic tick;
    logic div_run;
    adcc_pkg::adcc_rate_s rate;

    // comparator synchroniser
    logic comp_s1;
    logic comp_s2;
    logic comp_s3;
    logic comp_level;

    // bus decode
    adcc_sel_e sel;
    logic access;
    logic setup;
    logic wr_en;
    logic rd_en;
    logic csr_write;
    logic resh_read;
    logic select_change;
    logic [7:0] wbyte;
    logic [7:0] read_value;
    logic [`ADCC_IRQ_COUNT-1:0] irq_event;

    assign sel = adcc_decode(paddr);
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wr_en = access && pwrite && pstrb[0];
    assign rd_en = access && !pwrite;
    assign wbyte = pwdata[7:0];
    assign csr_write = wr_en && (sel == SEL_CSR);
    assign resh_read = rd_en && (sel == SEL_RESH);
    assign select_change = csr_write &&
        (wbyte[`ADCC_CSR_SEL_MSB:0] != input_select);
    assign pready = 1'b1;

    // control/status register; bit 7 and bits 4:3 take no write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast <= 1'(`ADCC_CSR_RESET >> `ADCC_CSR_FAST_BIT);
            converter_power_on <= 1'(`ADCC_CSR_RESET >> `ADCC_CSR_POWER_BIT);
            input_select <= 3'(`ADCC_CSR_RESET);
        end else if (csr_write) begin
            fast <= wbyte[`ADCC_CSR_FAST_BIT];
            converter_power_on <= wbyte[`ADCC_CSR_POWER_BIT];
            input_select <= wbyte[`ADCC_CSR_SEL_MSB:0];
        end
    end

    // amplifier control bits of the low register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {amp_offset_calibrate, quarter, amp_route_select} <=
                `ADCC_RESL_CTRL_RESET;
        end else if (wr_en && sel == SEL_RESL) begin
            amp_offset_calibrate <= wbyte[`ADCC_RESL_CAL_BIT];
            quarter <= wbyte[`ADCC_RESL_QUARTER_BIT];
            amp_route_select <= wbyte[`ADCC_RESL_ROUTE_BIT];
        end
    end

    // done flag: a finishing conversion wins over a clearing access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_flag <= 1'b0;
        end else if (conv_done) begin
            done_flag <= 1'b1;
        end else if (resh_read || csr_write) begin
            done_flag <= 1'b0;
        end
    end

    // comparator from the analog side, three stages
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comp_s1 <= 1'b0;
            comp_s2 <= 1'b0;
            comp_s3 <= 1'b0;
            comp_level <= 1'b0;
        end else begin
            comp_s1 <= comparator_high;
            comp_s2 <= comp_s1;
            comp_s3 <= comp_s2;
            if (comp_s2 == comp_s3) begin
                comp_level <= comp_s3;
            end
        end
    end

    // divider held while idle so the first sample phase has its full length
    assign div_run = converter_power_on && !restart && conv_state != adcc_pkg::CONV_OFF;
    assign rate.fast = fast;
    assign rate.quarter = quarter;

    adcc_clkdiv u_clkdiv (
        .pclk(pclk),
        .presetn(presetn),
        .run(div_run),
        .rate(rate),
        .tick(tick)
    );

    // a new input selection while powered restarts the cycle
    assign restart = select_change && converter_power_on;

    // successive approximation sequence, continuous while powered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_state <= adcc_pkg::CONV_OFF;
            tick_count <= 4'h0;
            bit_index <= 4'h0;
            trial <= 10'h000;
        end else if (!converter_power_on) begin
            conv_state <= adcc_pkg::CONV_OFF;
            tick_count <= 4'h0;
            trial <= 10'h000;
        end else if (restart) begin
            conv_state <= adcc_pkg::CONV_SAMPLE;
            tick_count <= 4'h0;
            trial <= 10'h000;
        end else begin
            case (conv_state)
                adcc_pkg::CONV_OFF: begin
                    conv_state <= adcc_pkg::CONV_SAMPLE;
                    tick_count <= 4'h0;
                end
                adcc_pkg::CONV_SAMPLE: begin
                    if (tick) begin
                        if (tick_count == `ADCC_SAMPLE_TICKS - 4'h1) begin
                            conv_state <= adcc_pkg::CONV_BIT;
                            tick_count <= 4'h0;
                            bit_index <= 4'(`ADCC_RESULT_BITS - 1);
                            trial <= 10'h200;
                        end else begin
                            tick_count <= tick_count + 4'h1;
                        end
                    end
                end
                adcc_pkg::CONV_BIT: begin
                    if (tick) begin
                        if (tick_count == `ADCC_BIT_TICKS - 4'h1) begin
                            tick_count <= 4'h0;
                            trial[bit_index] <= comp_level;
                            if (bit_index == 4'h0) begin
                                conv_state <= adcc_pkg::CONV_SAMPLE;
                            end else begin
                                trial[bit_index - 4'h1] <= 1'b1;
                                bit_index <= bit_index - 4'h1;
                            end
                        end else begin
                            tick_count <= tick_count + 4'h1;
                        end
                    end
                end
                default: begin
                    conv_state <= adcc_pkg::CONV_OFF;
                end
            endcase
        end
    end

    assign conv_done = converter_power_on && !restart && tick &&
        conv_state == adcc_pkg::CONV_BIT && bit_index == 4'h0 &&
        tick_count == `ADCC_BIT_TICKS - 4'h1;
    assign conv_abort = restart && conv_state != adcc_pkg::CONV_OFF;

    // both result fields written in one edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result <= 10'h000;
        end else if (conv_done) begin
            result <= {trial[9:1], comp_level};
        end
    end

    // sticky interrupt status; a new event wins over a clear
    assign irq_event[`ADCC_IRQ_DONE_BIT] = conv_done;
    assign irq_event[`ADCC_IRQ_ABORT_BIT] = conv_abort;

    generate
        for (genvar i = 0; i < `ADCC_IRQ_COUNT; i++) begin : g_irq
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    irq_status[i] <= 1'b0;
                end else if (irq_event[i]) begin
                    irq_status[i] <= 1'b1;
                end else if (wr_en && sel == SEL_IRQ_CLEAR && wbyte[i]) begin
                    irq_status[i] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_enable <= '0;
        end else if (wr_en && sel == SEL_IRQ_ENABLE) begin
            irq_enable <= wbyte[`ADCC_IRQ_COUNT-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_enable);
        end
    end

    // read mux
    always_comb begin
        read_value = 8'h00;
        case (sel)
            SEL_CSR: begin
                read_value[`ADCC_CSR_DONE_BIT] = done_flag;
                read_value[`ADCC_CSR_FAST_BIT] = fast;
                read_value[`ADCC_CSR_POWER_BIT] = converter_power_on;
                read_value[`ADCC_CSR_SEL_MSB:0] = input_select;
            end
            SEL_RESH: read_value = result[9:2];
            SEL_RESL: begin
                read_value[`ADCC_RESL_CAL_BIT] = amp_offset_calibrate;
                read_value[`ADCC_RESL_QUARTER_BIT] = quarter;
                read_value[`ADCC_RESL_ROUTE_BIT] = amp_route_select;
                read_value[1:0] = result[1:0];
            end
            SEL_IRQ_STATUS: read_value[`ADCC_IRQ_COUNT-1:0] = irq_status;
            SEL_IRQ_ENABLE: read_value[`ADCC_IRQ_COUNT-1:0] = irq_enable;
            default: read_value = 8'h00;
        endcase
    end

    // read data and error captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata <= {24'h00_0000, pwrite ? 8'h00 : read_value};
            pslverr <= (sel == SEL_NONE);
        end else if (!psel) begin
            pslverr <= 1'b0;
        end
    end

    // analog side controls, all from flip-flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog <= '0;
        end else begin
            analog.converter_power_on <= converter_power_on;
            analog.input_select <= input_select;
            analog.amp_offset_calibrate <= amp_offset_calibrate;
            analog.amp_route_select <= amp_route_select;
            analog.sample <= converter_power_on && conv_state == adcc_pkg::CONV_SAMPLE;
            analog.trial_code <= trial;
        end
    end
endmodule : adcc_top

// ==== logic/adcc_defines.svh ====
`ifndef ADCC_DEFINES_SVH
`define ADCC_DEFINES_SVH

// register indexes; byte address is four times the index
`define ADCC_IDX_CSR 8'h34
`define ADCC_IDX_RESH 8'h35
`define ADCC_IDX_RESL 8'h36
`define ADCC_IDX_IRQ_STATUS 8'h37
`define ADCC_IDX_IRQ_CLEAR 8'h38
`define ADCC_IDX_IRQ_ENABLE 8'h39

// control/status fields
`define ADCC_CSR_DONE_BIT 7
`define ADCC_CSR_FAST_BIT 6
`define ADCC_CSR_POWER_BIT 5
`define ADCC_CSR_SEL_MSB 2
`define ADCC_CSR_RESET 8'h00

// amplifier control / result-low fields
`define ADCC_RESL_CAL_BIT 4
`define ADCC_RESL_QUARTER_BIT 3
`define ADCC_RESL_ROUTE_BIT 2
`define ADCC_RESL_CTRL_RESET 3'h0

// interrupt status bits
`define ADCC_IRQ_DONE_BIT 0
`define ADCC_IRQ_ABORT_BIT 1
`define ADCC_IRQ_COUNT 2

// conversion timing in converter clock ticks
`define ADCC_SAMPLE_TICKS 4'h4
// a bit step outlasts the comparator synchroniser latency at full rate
`define ADCC_BIT_TICKS 4'h6
`define ADCC_RESULT_BITS 10

`endif

// ==== logic/adcc_pkg.sv ====
package adcc_pkg;

    typedef enum logic [1:0] {
        CONV_OFF,
        CONV_SAMPLE,
        CONV_BIT
    } adcc_conv_e;

    // signals toward the analog multiplexer, amplifier and converter
    typedef struct packed {
        logic converter_power_on;
        logic [2:0] input_select;
        logic amp_offset_calibrate;
        logic amp_route_select;
        logic sample;
        logic [9:0] trial_code;
    } adcc_analog_s;

    typedef struct packed {
        logic fast;
        logic quarter;
    } adcc_rate_s;

endpackage : adcc_pkg

// ==== logic/adcc_clkdiv.sv ====
`timescale 1ns/10ps
module adcc_clkdiv (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire adcc_pkg::adcc_rate_s rate,
    output logic tick
);
    logic [1:0] count;
    logic [1:0] last;

    // quarter wins over fast; fast alone gives every cycle
    always_comb begin
        if (rate.quarter) begin
            last = 2'h3;
        end else if (rate.fast) begin
            last = 2'h0;
        end else begin
            last = 2'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 2'h0;
        end else if (!run || count >= last) begin
            count <= 2'h0;
        end else begin
            count <= count + 2'h1;
        end
    end

    assign tick = run && (count >= last);
endmodule : adcc_clkdiv

// ==== testbench/adcc_asserts.sv ====
`timescale 1ns/10ps
`include "adcc_defines.svh"
module adcc_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq,
    input wire adcc_pkg::adcc_analog_s analog,
    input wire logic comparator_high
);
    localparam logic [11:0] A_CSR = {2'h0, `ADCC_IDX_CSR, 2'h0};
    localparam logic [11:0] A_LOW = {2'h0, `ADCC_IDX_RESL, 2'h0};
    logic acc;
    logic wr_csr;
    logic wr_low;
    logic fast;
    logic quarter;
    logic [4:0] run_len;
    logic [4:0] exp_len;
    assign acc = psel && penable;
    assign wr_csr = acc && pwrite && pstrb[0] && paddr == A_CSR;
    assign wr_low = acc && pwrite && pstrb[0] && paddr == A_LOW;
    assign exp_len = quarter ? 5'h10 : (fast ? 5'h04 : 5'h08);
    // rate bits as last written by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast <= 1'b0;
            quarter <= 1'b0;
        end else begin
            if (wr_csr) fast <= pwdata[6];
            if (wr_low) quarter <= pwdata[3];
        end
    end
    // length of the sample phase; 1F marks a run broken by a restart
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) run_len <= 5'h00;
        else if (!analog.sample) run_len <= 5'h00;
        else if ($changed(analog.input_select)) run_len <= 5'h1F;
        else if (run_len != 5'h1F) run_len <= run_len + 5'h01;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    csr_read_zero_a: assert property (
        acc && !pwrite && paddr == A_CSR |-> prdata[4:3] == 2'h0)
        else $error("reserved control bits read nonzero");
    low_top_zero_a: assert property (
        acc && !pwrite && paddr == A_LOW |-> prdata[7:5] == 3'h0)
        else $error("low register top bits read nonzero");
    power_follow_a: assert property (
        wr_csr |-> ##2 analog.converter_power_on == $past(pwdata[5], 2))
        else $error("power output does not follow write");
    power_hold_a: assert property (
        $changed(analog.converter_power_on) |-> $past(wr_csr, 2))
        else $error("power output changed without a write");
    select_follow_a: assert property (
        wr_csr |-> ##2 analog.input_select == $past(pwdata[2:0], 2))
        else $error("input select does not follow write");
    amp_follow_a: assert property (
        wr_low |-> ##2 analog.amp_offset_calibrate == $past(pwdata[4], 2)
            && analog.amp_route_select == $past(pwdata[2], 2))
        else $error("amplifier controls do not follow write");
    off_idle_a: assert property (
        !analog.converter_power_on |-> !analog.sample)
        else $error("sampling while powered off");
    sample_len_a: assert property (
        $fell(analog.sample) && analog.converter_power_on && run_len != 5'h1F
            |-> run_len == exp_len)
        else $error("sample phase length wrong for clock rate");
    restart_a: assert property (
        $changed(analog.input_select) && analog.converter_power_on
            && $past(analog.converter_power_on) |-> ##[0:12] analog.sample)
        else $error("no restart after input change");
    cover property ($fell(analog.sample) && quarter);
    cover property ($fell(analog.sample) && fast && !quarter);
    cover property ($rose(irq));
endmodule : adcc_asserts

bind adcc_top adcc_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .analog(analog),
    .comparator_high(comparator_high));

// ==== testbench/adcc_analog_model.sv ====
`timescale 1ns/10ps
module adcc_analog_model (
    input wire logic pclk,
    input wire adcc_pkg::adcc_analog_s analog,
    output logic comparator_high
);
    logic [9:0] level;
    logic [12:0] gained;
    logic [9:0] seen;
    logic flip = 1'b0;
    // each input sits at its own fixed level
    assign level = {analog.input_select, 7'h15};
    assign gained = analog.amp_offset_calibrate ? 13'h0000 : {level, 3'h0};
    assign seen = !analog.amp_route_select ? level :
        (gained > 13'h03FF ? 10'h3FF : gained[9:0]);
    // unpowered comparator output is meaningless
    always @(posedge pclk) flip <= !flip;
    assign comparator_high = analog.converter_power_on ? (seen >= analog.trial_code) : flip;
endmodule : adcc_analog_model

// ==== testbench/adc_control_registers_test.sv ====
`timescale 1ns/10ps
`include "adcc_defines.svh"
module adc_control_registers_test;
    localparam logic [7:0] I_CSR = `ADCC_IDX_CSR;
    localparam logic [7:0] I_HI = `ADCC_IDX_RESH;
    localparam logic [7:0] I_LO = `ADCC_IDX_RESL;
    logic pclk;
    logic presetn;
    logic psel, penable, pwrite, pready, pslverr, irq, comparator_high, err;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
    logic [31:0] prdata;
    logic [31:0] rv;
    adcc_pkg::adcc_analog_s analog;
    int n_errors;
    int cmp_count;

    adcc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .analog(analog),
        .comparator_high(comparator_high));
    adcc_analog_model u_ana (.pclk(pclk), .analog(analog), .comparator_high(comparator_high));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = !pclk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rv = prdata;
        err = pslverr;
        check("pready", 32'(pready), 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic wait_done();
        int n;
        n = 0;
        do begin
            xfer(1'b0, I_CSR, 8'h00);
            n++;
        end while (rv[7] !== 1'b1 && n < 400);
        check("done flag", 32'(rv[7]), 32'h1);
    endtask : wait_done

    task automatic convert(input logic [7:0] csr, input logic [7:0] low, input logic [9:0] exp);
        xfer(1'b1, I_CSR, 8'h00);
        xfer(1'b1, I_LO, low);
        xfer(1'b1, I_CSR, csr);
        wait_done();
        xfer(1'b0, I_LO, 8'h00);
        check("result low", rv, {27'h0, low[4:2], exp[1:0]});
        xfer(1'b0, I_HI, 8'h00);
        check("result high", rv, {24'h0, exp[9:2]});
        xfer(1'b0, I_CSR, 8'h00);
        check("csr after high read", rv, {25'h0, csr[6:5], 2'h0, csr[2:0]});
    endtask : convert

    task automatic tally_and_finish();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        #400000;
        n_errors++;
        tally_and_finish();
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        n_errors = 0;
        cmp_count = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, I_CSR, 8'h00);
        check("csr reset", rv, 32'h0);
        xfer(1'b0, I_LO, 8'h00);
        check("low reset", rv & 32'hFC, 32'h0);
        xfer(1'b1, I_CSR, 8'h9E);
        xfer(1'b0, I_CSR, 8'h00);
        check("csr fixed bits", rv, 32'h06);
        xfer(1'b1, I_LO, 8'hE3);
        xfer(1'b0, I_LO, 8'h00);
        check("low top bits", rv & 32'hFC, 32'h0);
        xfer(1'b0, 8'h50, 8'h00);
        check("unmapped error", {31'h0, err}, 32'h1);
        // every input at full rate, then the slower rates and the amplifier
        for (int c = 0; c < 7; c++) convert({5'h0C, 3'(c)}, 8'h00, {3'(c), 7'h15});
        convert(8'h23, 8'h00, 10'h195);
        convert(8'h20, 8'h0C, 10'h0A8);
        convert(8'h25, 8'h0C, 10'h3FF);
        convert(8'h62, 8'h1C, 10'h000);
        wait_done();
        xfer(1'b1, I_CSR, 8'h62);
        xfer(1'b0, I_CSR, 8'h00);
        check("flag after write", 32'(rv[7]), 32'h0);
        // abort by input change, with interrupts enabled
        xfer(1'b1, 8'h38, 8'h03);
        xfer(1'b1, 8'h39, 8'h03);
        xfer(1'b1, I_CSR, 8'h00);
        xfer(1'b1, I_LO, 8'h00);
        xfer(1'b1, I_CSR, 8'h61);
        wait_done();
        xfer(1'b1, I_CSR, 8'h64);
        xfer(1'b0, I_CSR, 8'h00);
        check("flag after switch", rv, 32'h64);
        wait_done();
        xfer(1'b0, I_HI, 8'h00);
        check("switched result", rv, 32'h85);
        xfer(1'b0, 8'h37, 8'h00);
        check("irq status", rv, 32'h3);
        check("irq line", 32'(irq), 32'h1);
        xfer(1'b1, 8'h39, 8'h00);
        repeat (2) @(posedge pclk);
        check("irq masked", 32'(irq), 32'h0);
        xfer(1'b1, I_CSR, 8'h00);
        xfer(1'b1, 8'h38, 8'h03);
        xfer(1'b0, 8'h37, 8'h00);
        check("irq cleared", rv, 32'h0);
        xfer(1'b1, 8'h39, 8'h03);
        repeat (2) @(posedge pclk);
        check("irq idle", 32'(irq), 32'h0);
        tally_and_finish();
    end
endmodule : adc_control_registers_test
